// file: hw/atfcc_pkg.sv
// constants and types shared by the task-file command core
package atfcc_pkg;
  // task-file offsets (chip select 0 block)
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_ERROR = 3'h1;
  localparam logic [2:0] ADDR_SCNT = 3'h2;
  localparam logic [2:0] ADDR_SNUM = 3'h3;
  localparam logic [2:0] ADDR_CYL_LO = 3'h4;
  localparam logic [2:0] ADDR_CYL_HI = 3'h5;
  localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;
  // control block offsets (chip select 1 block)
  localparam logic [2:0] ADDR_DEVCTL = 3'h6;
  localparam logic [2:0] ADDR_DRVADDR = 3'h7;
  // device/head selector fields
  localparam int DH_LBA_BIT = 6;
  localparam int DH_CARD_BIT = 4;
  localparam logic [7:0] DH_FIXED_ONES = 8'hA0;
  // device control fields
  localparam int DC_SRST_BIT = 2;
  localparam int DC_NIEN_BIT = 1;
  // reset values
  localparam logic [7:0] RST_ERROR = 8'h01;
  localparam logic [7:0] RST_SCNT = 8'h01;
  localparam logic [7:0] RST_SNUM = 8'h01;
  localparam logic [7:0] RST_CYL = 8'h00;
  localparam logic [7:0] RST_DEVHEAD = 8'hA0;
  // opcodes
  localparam logic [7:0] OP_CHECK_PWR = 8'hE5;
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_FLUSH = 8'hE7;
  localparam logic [7:0] OP_IDENTIFY = 8'hEC;
  localparam logic [7:0] OP_IDLE = 8'hE3;
  localparam logic [7:0] OP_IDLE_IMM = 8'hE1;
  localparam logic [7:0] OP_RD_BUF = 8'hE4;
  localparam logic [7:0] OP_RD_DMA = 8'hC8;
  localparam logic [7:0] OP_RD_SECT = 8'h20;
  localparam logic [7:0] OP_RD_VERIFY = 8'h40;
  localparam logic [7:0] OP_SET_FEAT = 8'hEF;
  localparam logic [7:0] OP_SET_MULT = 8'hC6;
  localparam logic [7:0] OP_SLEEP = 8'hE6;
  localparam logic [7:0] OP_SMART = 8'hB0;
  localparam logic [7:0] OP_STANDBY = 8'hE2;
  localparam logic [7:0] OP_STANDBY_IMM = 8'hE0;
  localparam logic [7:0] OP_WR_BUF = 8'hE8;
  localparam logic [7:0] OP_WR_DMA = 8'hCA;
  localparam logic [7:0] OP_WR_MULT = 8'hC5;
  localparam logic [7:0] OP_WR_SECT = 8'h30;
  // answers
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] PM_SLEEPING = 8'h00;
  localparam logic [7:0] PM_IDLE = 8'hFF;
  localparam logic [7:0] LAST_WORD = 8'hFF;
  localparam logic [8:0] FULL_COUNT = 9'h100;
  // identify words that are not zero
  localparam logic [15:0] ID_W0 = 16'h044A;
  localparam logic [15:0] ID_W47 = 16'h8001;
  localparam logic [15:0] ID_W49 = 16'h0F00;
  localparam logic [15:0] ID_W53 = 16'h0007;
  localparam logic [15:0] ID_W64 = 16'h0003;
  localparam logic [15:0] ID_W65_68 = 16'h0078;
  localparam logic [15:0] ID_W80 = 16'h0080;
  localparam logic [15:0] ID_W82 = 16'h742B;

  typedef enum logic [5:0] {
    ST_INIT = 6'b000001,
    ST_IDLE = 6'b000010,
    ST_EXEC = 6'b000100,
    ST_MEDIA = 6'b001000,
    ST_XFER = 6'b010000,
    ST_FLUSH = 6'b100000
  } atfcc_state_e;
endpackage

// file: hw/atfcc_core.sv
// task-file registers, status and command interpreter of the storage card
// What this block does
// - device/head selector always reads ones in bits 7 and 5
// - selector bit 6 picks block addressing (1) or cylinder/head/sector (0)
// - selector bit 4 picks card 0 or card 1
// - selector low nibble is head 3..0, or block address bits 27..24
// - status read clears pending interrupt; alternate status read does not
// - busy set while device owns registers; task-file writes then locked out
// - ready reads zero from power-up until a command can be accepted
// - status bit 5 is write fault, bit 4 mirrors ready
// - status bit 3 set while a data word must move through data register
// - DMA request only while busy or data request is set
// - bit 2 flags a corrected error and never stops a read
// - bit 0 flags a failed command with detail in error register; bit 1 zero
// - device control accepted any time, even busy; bits 7..3 and 0 ignored
// - device control bit 2 holds the card in soft reset until cleared
// - device control bit 1 masks interrupts; cleared at power-up reset, kept through soft reset
// - drive address shows inverted head bits, write flag, active card bits
// - supported opcodes decoded; address fields passed where commands use them
// - power query loads sector count with 00h sleeping or FFh idle
// - diagnostic ignores card select and returns result in error register
// - cache flush holds busy until flushed, then ready with clean flags
// - failed flush sets abort and error, loads address of first bad block
// - identify returns one sector, sector-read protocol, reserved words zero
// - sector count zero means 256 sectors
// - block mode: sector number 7..0, cylinder low 15..8, high 23..16
`timescale 1ns/1ps
module atfcc_core
  import atfcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] addr,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic dmack_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic intrq,
  output logic dma_request,
  input wire logic card1_strap,
  input wire logic media_ready,
  input wire logic media_drq,
  input wire logic media_done,
  input wire logic media_err,
  input wire logic media_fault,
  input wire logic media_corrected_flag,
  input wire logic [15:0] media_rdata,
  input wire logic [7:0] diag_code,
  input wire logic flush_done,
  input wire logic flush_fail,
  input wire logic [27:0] fail_lba,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_feature,
  output logic cmd_lba_mode,
  output logic [27:0] cmd_lba,
  output logic [8:0] cmd_sectors,
  output logic flush_req,
  output logic media_rd,
  output logic media_wr,
  output logic [15:0] media_wdata
);
  import atfcc_pkg::*;

  typedef struct packed {
    atfcc_state_e state;
    logic [7:0] err;
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dh;
    logic srst;
    logic nien;
    logic rdy;
    logic df;
    logic corrected_flag;
    logic errf;
    logic pend;
    logic intrq;
    logic dmarq;
    logic [15:0] dout;
    logic doe;
    logic ior_p;
    logic iow_p;
    logic [7:0] wcnt;
    logic sleep;
    logic ident;
    logic is_dma;
    logic is_write;
    logic [7:0] cmd;
    logic cmd_valid;
    logic [7:0] cmd_feat;
    logic lba_mode;
    logic [27:0] lba;
    logic [8:0] nsect;
    logic flush_req;
    logic media_rd;
    logic media_wr;
    logic [15:0] wdata;
  } atfcc_state_s;

  atfcc_state_s s_q, s_d;

  // helper terms, filled by the one combinational process
  logic rd_fall, wr_fall, tf_sel, cb_sel, dma_sel, selected;
  logic stat_rd, alt_rd, set_ev, busy, drq;
  logic [7:0] status;

  function automatic logic [15:0] ident_word(input logic [7:0] idx);
    unique case (idx)
      8'd0: ident_word = ID_W0;
      8'd47: ident_word = ID_W47;
      8'd49: ident_word = ID_W49;
      8'd53: ident_word = ID_W53;
      8'd64: ident_word = ID_W64;
      8'd65, 8'd66, 8'd67, 8'd68: ident_word = ID_W65_68;
      8'd80: ident_word = ID_W80;
      8'd82: ident_word = ID_W82;
      default: ident_word = 16'h0000;
    endcase
  endfunction

  function automatic logic op_known(input logic [7:0] op);
    unique case (op)
      OP_IDLE, OP_IDLE_IMM, OP_RD_BUF, OP_RD_DMA, OP_RD_SECT, OP_RD_VERIFY,
      OP_SET_FEAT, OP_SET_MULT, OP_SLEEP, OP_SMART, OP_STANDBY, OP_STANDBY_IMM,
      OP_WR_BUF, OP_WR_DMA, OP_WR_MULT, OP_WR_SECT: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  endfunction

  function automatic logic op_writes(input logic [7:0] op);
    op_writes = (op == OP_WR_SECT) || (op == OP_WR_MULT) || (op == OP_WR_DMA) ||
      (op == OP_WR_BUF);
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.cmd_valid = 1'b0;
    s_d.flush_req = 1'b0;
    s_d.media_rd = 1'b0;
    s_d.media_wr = 1'b0;
    s_d.ior_p = ior_n;
    s_d.iow_p = iow_n;
    rd_fall = s_q.ior_p && !ior_n;
    wr_fall = s_q.iow_p && !iow_n;
    tf_sel = cs0_n == 1'b0 && cs1_n == 1'b1 && dmack_n;
    cb_sel = cs0_n == 1'b1 && cs1_n == 1'b0 && dmack_n;
    dma_sel = cs0_n && cs1_n && !dmack_n;
    selected = s_q.dh[DH_CARD_BIT] == card1_strap;
    busy = s_q.state != ST_IDLE && s_q.state != ST_XFER;
    drq = s_q.state == ST_XFER;
    // bit 4 mirrors ready, bit 1 is tied low
    status = {busy, s_q.rdy, s_q.df, s_q.rdy, drq, s_q.corrected_flag, 1'b0, s_q.errf};
    stat_rd = rd_fall && tf_sel && addr == ADDR_STATUS && selected;
    alt_rd = rd_fall && cb_sel && addr == ADDR_DEVCTL && selected;
    set_ev = 1'b0;

    // host reads: the bus drives only while the strobe is low and decoded
    s_d.doe = !ior_n && selected && ((tf_sel && addr != ADDR_DATA) || cb_sel ||
      (drq && !s_q.is_write && (s_q.is_dma ? dma_sel : (tf_sel && addr == ADDR_DATA))));
    if (rd_fall && selected) begin
      if (tf_sel) begin
        unique case (addr)
          ADDR_ERROR: s_d.dout = {8'h00, s_q.err};
          ADDR_SCNT: s_d.dout = {8'h00, s_q.scnt};
          ADDR_SNUM: s_d.dout = {8'h00, s_q.snum};
          ADDR_CYL_LO: s_d.dout = {8'h00, s_q.cyl_lo};
          ADDR_CYL_HI: s_d.dout = {8'h00, s_q.cyl_hi};
          ADDR_DEVHEAD: s_d.dout = {8'h00, s_q.dh};
          ADDR_STATUS: s_d.dout = {8'h00, status};
          default: s_d.dout = s_q.dout;
        endcase
      end else if (cb_sel && addr == ADDR_DEVCTL) begin
        s_d.dout = {8'h00, status};
      end else if (cb_sel && addr == ADDR_DRVADDR) begin
        s_d.dout = {8'h00, 1'b0, !s_q.is_write || !drq, ~s_q.dh[3:0],
          !(s_q.dh[DH_CARD_BIT] && card1_strap),
          !(!s_q.dh[DH_CARD_BIT] && !card1_strap)};
      end
    end
    // status read clears, alternate read leaves it; a new event wins
    if (stat_rd) begin
      s_d.pend = 1'b0;
    end

    // register writes, locked out while busy or transferring
    if (wr_fall && tf_sel && s_q.state == ST_IDLE) begin
      unique case (addr)
        ADDR_ERROR: s_d.feat = data_in[7:0];
        ADDR_SCNT: s_d.scnt = data_in[7:0];
        ADDR_SNUM: s_d.snum = data_in[7:0];
        ADDR_CYL_LO: s_d.cyl_lo = data_in[7:0];
        ADDR_CYL_HI: s_d.cyl_hi = data_in[7:0];
        ADDR_DEVHEAD: s_d.dh = data_in[7:0] | DH_FIXED_ONES;
        default: ;
      endcase
    end
    if (wr_fall && cb_sel && addr == ADDR_DEVCTL) begin
      s_d.srst = data_in[DC_SRST_BIT];
      s_d.nien = data_in[DC_NIEN_BIT];
    end

    unique case (s_q.state)
      ST_INIT: begin
        s_d.rdy = 1'b0;
        if (media_ready && !s_d.srst) begin
          s_d.rdy = 1'b1;
          s_d.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wr_fall && tf_sel && addr == ADDR_STATUS &&
            (selected || data_in[7:0] == OP_DIAG)) begin
          s_d.cmd = data_in[7:0];
          s_d.corrected_flag = 1'b0;
          s_d.df = 1'b0;
          s_d.errf = 1'b0;
          s_d.ident = 1'b0;
          s_d.wcnt = 8'h00;
          s_d.is_dma = data_in[7:0] == OP_RD_DMA || data_in[7:0] == OP_WR_DMA;
          s_d.is_write = op_writes(data_in[7:0]);
          s_d.cmd_feat = s_q.feat;
          s_d.lba_mode = s_q.dh[DH_LBA_BIT];
          // block mode packs the address; otherwise fields pass as cylinder/head/sector
          s_d.lba = {s_q.dh[3:0], s_q.cyl_hi, s_q.cyl_lo, s_q.snum};
          s_d.nsect = {s_q.scnt == 8'h00, s_q.scnt};
          s_d.err = 8'h00;
          if (data_in[7:0] == OP_FLUSH) begin
            s_d.flush_req = 1'b1;
            s_d.state = ST_FLUSH;
          end else if (data_in[7:0] == OP_IDENTIFY) begin
            s_d.ident = 1'b1;
            s_d.state = ST_EXEC;
          end else if (op_known(data_in[7:0])) begin
            s_d.cmd_valid = 1'b1;
            s_d.sleep = data_in[7:0] == OP_SLEEP;
            s_d.state = ST_MEDIA;
          end else begin
            s_d.state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        // one busy cycle for commands answered from within
        set_ev = 1'b1;
        s_d.state = ST_IDLE;
        if (s_q.cmd == OP_CHECK_PWR) begin
          s_d.scnt = s_q.sleep ? PM_SLEEPING : PM_IDLE;
        end else if (s_q.cmd == OP_DIAG) begin
          s_d.err = diag_code;
        end else if (s_q.ident) begin
          s_d.state = ST_XFER;
        end else begin
          s_d.err = ERR_ABORT;
          s_d.errf = 1'b1;
        end
      end
      ST_MEDIA: begin
        if (media_corrected_flag) begin
          s_d.corrected_flag = 1'b1;
        end
        if (media_done) begin
          set_ev = 1'b1;
          s_d.state = ST_IDLE;
          s_d.df = media_fault;
          s_d.errf = media_err || media_fault;
          s_d.err = (media_err || media_fault) ? ERR_ABORT : 8'h00;
          if (!media_err && !media_fault && s_q.nsect != 9'h000) begin
            s_d.scnt = 8'h00;
          end
        end else if (media_drq) begin
          set_ev = !s_q.is_dma;
          s_d.state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (media_corrected_flag) begin
          s_d.corrected_flag = 1'b1;
        end
        if (s_q.is_write ? wr_fall : rd_fall) begin
          if (s_q.is_dma ? dma_sel : (tf_sel && addr == ADDR_DATA && selected)) begin
            s_d.wcnt = s_q.wcnt + 8'h01;
            if (s_q.ident) begin
              s_d.dout = ident_word(s_q.wcnt);
            end else if (s_q.is_write) begin
              s_d.media_wr = 1'b1;
              s_d.wdata = data_in;
            end else begin
              s_d.media_rd = 1'b1;
              s_d.dout = media_rdata;
            end
            if (s_q.wcnt == LAST_WORD) begin
              s_d.state = s_q.ident ? ST_IDLE : ST_MEDIA;
              set_ev = s_q.ident;
            end
          end
        end
      end
      ST_FLUSH: begin
        if (flush_done || flush_fail) begin
          set_ev = 1'b1;
          s_d.state = ST_IDLE;
          s_d.df = 1'b0;
          s_d.errf = flush_fail;
          if (flush_fail) begin
            s_d.err = ERR_ABORT;
            s_d.snum = fail_lba[7:0];
            s_d.cyl_lo = fail_lba[15:8];
            s_d.cyl_hi = fail_lba[23:16];
            s_d.dh = {s_q.dh[7:4], fail_lba[27:24]};
          end
        end
      end
      default: s_d.state = ST_INIT;
    endcase
    if (set_ev) begin
      s_d.pend = 1'b1;
    end

    // soft reset: back to the power-up register image, mask bit kept as written
    if (s_d.srst) begin
      s_d.state = ST_INIT;
      s_d.rdy = 1'b0;
      s_d.pend = 1'b0;
      s_d.errf = 1'b0;
      s_d.df = 1'b0;
      s_d.corrected_flag = 1'b0;
      s_d.sleep = 1'b0;
      s_d.err = RST_ERROR;
      s_d.scnt = RST_SCNT;
      s_d.snum = RST_SNUM;
      s_d.cyl_lo = RST_CYL;
      s_d.cyl_hi = RST_CYL;
      s_d.dh = RST_DEVHEAD;
    end
    s_d.intrq = s_d.pend && !s_d.nien && selected;
    s_d.dmarq = s_q.is_dma && s_d.state == ST_XFER && !s_d.srst;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= ST_INIT;
      s_q.err <= RST_ERROR;
      s_q.scnt <= RST_SCNT;
      s_q.snum <= RST_SNUM;
      s_q.cyl_lo <= RST_CYL;
      s_q.cyl_hi <= RST_CYL;
      s_q.dh <= RST_DEVHEAD;
      s_q.ior_p <= 1'b1;
      s_q.iow_p <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.dout;
  assign data_oe = s_q.doe;
  assign intrq = s_q.intrq;
  assign dma_request = s_q.dmarq;
  assign cmd_valid = s_q.cmd_valid;
  assign cmd_opcode = s_q.cmd;
  assign cmd_feature = s_q.cmd_feat;
  assign cmd_lba_mode = s_q.lba_mode;
  assign cmd_lba = s_q.lba;
  assign cmd_sectors = s_q.nsect;
  assign flush_req = s_q.flush_req;
  assign media_rd = s_q.media_rd;
  assign media_wr = s_q.media_wr;
  assign media_wdata = s_q.wdata;

  dh_fixed_a: assert property (@(posedge clk) disable iff (rst)
    s_q.dh[7] && s_q.dh[5]) else $error("selector fixed bits not one");

  stat_clear_a: assert property (@(posedge clk) disable iff (rst)
    (stat_rd && !set_ev) |=> !s_q.pend && !intrq) else $error("status read kept irq");

  alt_keep_a: assert property (@(posedge clk) disable iff (rst)
    (alt_rd && !stat_rd && !s_d.srst) |=> s_q.pend || !$past(s_q.pend))
    else $error("alternate status read cleared irq");

  dma_gate_a: assert property (@(posedge clk) disable iff (rst)
    dma_request |-> (busy || drq)) else $error("dma request without busy or drq");

  irq_mask_a: assert property (@(posedge clk) disable iff (rst)
    intrq |-> !s_q.nien) else $error("interrupt while masked");

  srst_hold_a: assert property (@(posedge clk) disable iff (rst)
    s_q.srst |-> s_q.state == ST_INIT && !s_q.rdy) else $error("soft reset not held");

  stat_bits_a: assert property (@(posedge clk) disable iff (rst)
    stat_rd |=> data_out[1] == 1'b0 && data_out[7] == $past(busy) &&
      data_out[4] == data_out[6]) else $error("status image wrong");

  pm_answer_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.state == ST_EXEC && s_q.cmd == OP_CHECK_PWR && !s_d.srst) |=>
      s_q.scnt == ($past(s_q.sleep) ? PM_SLEEPING : PM_IDLE) && s_q.pend)
    else $error("power query answer wrong");

  count_zero_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid |-> cmd_sectors == ((s_q.scnt == 8'h00) ? FULL_COUNT : {1'b0, s_q.scnt}))
    else $error("sector count not expanded");

  flush_fail_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.state == ST_FLUSH && flush_fail && !s_d.srst) |=>
      s_q.err == ERR_ABORT && s_q.errf && s_q.snum == $past(fail_lba[7:0]))
    else $error("flush failure not reported");
endmodule

// file: testbench/atfcc_host_model.sv
// host controller model that moves one register or data word per call
`timescale 1ns/1ps
module atfcc_host_model (
  input wire logic clk,
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] addr,
  output logic ior_n,
  output logic iow_n,
  output logic dmack_n,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic data_oe
);
  initial begin
    cs0_n = 1'b1;
    cs1_n = 1'b1;
    addr = 3'h0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    dmack_n = 1'b1;
    data_in = 16'hFFFF;
  end

  // decode is set up one cycle ahead so the strobe fall sees it stable
  task automatic xfer(input logic c0, input logic c1, input logic dk, input logic [2:0] a,
                      input logic rd, input logic [15:0] wd, output logic [15:0] rdv,
                      output logic oe);
    @(negedge clk);
    cs0_n = c0;
    cs1_n = c1;
    dmack_n = dk;
    addr = a;
    data_in = wd;
    @(negedge clk);
    if (rd) begin
      ior_n = 1'b0;
    end else begin
      iow_n = 1'b0;
    end
    // strobe held over two rising edges; the fall is seen and the answer registered at the first
    @(negedge clk);
    @(negedge clk);
    rdv = data_out;
    oe = data_oe;
    ior_n = 1'b1;
    iow_n = 1'b1;
    cs0_n = 1'b1;
    cs1_n = 1'b1;
    dmack_n = 1'b1;
    // released lines show garbage, not the last value
    data_in = ~wd;
    addr = ~a;
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the task-file command core
`timescale 1ns/1ps
module testbench;
  import atfcc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs0_n, cs1_n, ior_n, iow_n, dmack_n, data_oe, intrq, dma_request;
  logic cmd_valid, cmd_lba_mode, flush_req, media_rd, media_wr;
  logic [2:0] addr;
  logic [15:0] data_in, data_out, media_rdata, media_wdata, r;
  logic media_ready = 1'b0, media_drq = 1'b0, media_done = 1'b0, media_err = 1'b0;
  logic media_fault = 1'b0, media_corrected_flag = 1'b0, flush_done = 1'b0, flush_fail = 1'b0;
  logic card1_strap = 1'b0, o;
  logic [7:0] diag_code = 8'h01;
  logic [7:0] cmd_opcode, cmd_feature;
  logic [27:0] fail_lba = 28'h0000000;
  logic [27:0] cmd_lba;
  logic [8:0] cmd_sectors;
  logic [7:0] codes [4] = '{8'h01, 8'h03, 8'h05, 8'h81};
  int n_mismatch = 0, tests_run = 0, n_cmd = 0, n_flush = 0, n_rd = 0, n_wr = 0;

  always #10 clk = ~clk;
  assign media_rdata = {8'hC0, 8'(n_rd)};
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (flush_req === 1'b1) n_flush <= n_flush + 1;
    if (media_rd === 1'b1) n_rd <= n_rd + 1;
    if (media_wr === 1'b1) n_wr <= n_wr + 1;
  end

  atfcc_core atfcc_core_i (.clk, .rst, .cs0_n, .cs1_n, .addr, .ior_n, .iow_n, .dmack_n,
    .data_in, .data_out, .data_oe, .intrq, .dma_request, .card1_strap, .media_ready,
    .media_drq, .media_done, .media_err, .media_fault, .media_corrected_flag, .media_rdata,
    .diag_code, .flush_done, .flush_fail, .fail_lba, .cmd_valid, .cmd_opcode, .cmd_feature,
    .cmd_lba_mode, .cmd_lba, .cmd_sectors, .flush_req, .media_rd, .media_wr, .media_wdata);
  atfcc_host_model atfcc_host_model_i (.clk, .cs0_n, .cs1_n, .addr, .ior_n, .iow_n,
    .dmack_n, .data_in, .data_out, .data_oe);

  task automatic close_out;
    $display("%0d checks made, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask

  // ctl = 1 picks the control block, 0 the task file
  task automatic wr(input logic ctl, input logic [2:0] a, input logic [7:0] d);
    logic [15:0] rv;
    logic oev;
    atfcc_host_model_i.xfer(ctl, ~ctl, 1'b1, a, 1'b0, {8'h00, d}, rv, oev);
  endtask

  task automatic rc(input logic ctl, input logic [2:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string n);
    logic [15:0] rv;
    logic oev;
    atfcc_host_model_i.xfer(ctl, ~ctl, 1'b1, a, 1'b1, 16'h0000, rv, oev);
    chk(n, {24'h0, e}, {24'h0, rv[7:0] & m});
    chk({n, " enable"}, 1, 32'(oev));
  endtask

  // polls the alternate copy so a pending interrupt survives
  task automatic wait_idle;
    logic [15:0] rv = 16'h0080;
    logic oev;
    int k;
    for (k = 0; k < 40 && rv[7] !== 1'b0; k++) begin
      atfcc_host_model_i.xfer(1'b1, 1'b0, 1'b1, ADDR_DEVCTL, 1'b1, 16'h0000, rv, oev);
    end
    if (rv[7] !== 1'b0) begin
      $display("CHECK FAILED idle wait expected busy 0 seen %b", rv[7]);
      n_mismatch++;
      close_out;
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic done_test(input string n);
    $display("test %s ended, %0d mismatches so far", n, n_mismatch);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rc(1'b1, ADDR_DEVCTL, 8'hC0, 8'h80, "busy not ready");
    media_ready = 1'b1;
    wait_idle;
    rc(1'b0, ADDR_STATUS, 8'hFF, 8'h50, "idle status");
    rc(1'b0, ADDR_ERROR, 8'hFF, 8'h01, "error after reset");
    done_test("reset");
    wr(1'b0, ADDR_DEVHEAD, 8'h00);
    rc(1'b0, ADDR_DEVHEAD, 8'hFF, 8'hA0, "selector zero");
    wr(1'b0, ADDR_DEVHEAD, 8'h4B);
    rc(1'b0, ADDR_DEVHEAD, 8'hFF, 8'hEB, "selector lba");
    rc(1'b1, ADDR_DRVADDR, 8'h7F, 8'h52, "drive address");
    card1_strap = 1'b1;
    wr(1'b0, ADDR_DEVHEAD, 8'h10);
    rc(1'b1, ADDR_DRVADDR, 8'h03, 8'h01, "card 1 address");
    wr(1'b0, ADDR_DEVHEAD, 8'h4B);
    card1_strap = 1'b0;
    done_test("selector");
    wr(1'b0, ADDR_SNUM, 8'h11);
    wr(1'b0, ADDR_CYL_LO, 8'h22);
    wr(1'b0, ADDR_CYL_HI, 8'h33);
    wr(1'b0, ADDR_SCNT, 8'h00);
    wr(1'b0, ADDR_ERROR, 8'h5A);
    wr(1'b0, ADDR_STATUS, OP_RD_DMA);
    @(negedge clk);
    chk("command count", 1, n_cmd);
    chk("opcode", 32'(OP_RD_DMA), 32'(cmd_opcode));
    chk("feature", 32'h5A, 32'(cmd_feature));
    chk("block address", 32'h0B332211, 32'(cmd_lba));
    chk("lba mode", 1, 32'(cmd_lba_mode));
    chk("sector count", 32'h100, 32'(cmd_sectors));
    media_drq = 1'b1;
    repeat (3) @(negedge clk);
    chk("dma request", 1, 32'(dma_request));
    rc(1'b1, ADDR_DEVCTL, 8'h88, 8'h08, "dma phase status");
    media_drq = 1'b0;
    for (int i = 0; i < 256; i++) begin
      atfcc_host_model_i.xfer(1'b1, 1'b1, 1'b0, ADDR_DATA, 1'b1, 16'h0000, r, o);
      chk("dma data", 32'hC000 + i, 32'(r));
    end
    chk("dma words", 256, n_rd);
    chk("dma request off", 0, 32'(dma_request));
    pulse(media_done);
    wait_idle;
    chk("completion irq", 1, 32'(intrq));
    rc(1'b1, ADDR_DEVCTL, 8'hFF, 8'h50, "alt status");
    chk("irq kept", 1, 32'(intrq));
    rc(1'b0, ADDR_STATUS, 8'hFF, 8'h50, "status");
    chk("irq cleared", 0, 32'(intrq));
    rc(1'b0, ADDR_SCNT, 8'hFF, 8'h00, "count at success");
    done_test("dma read");
    wr(1'b0, ADDR_STATUS, OP_CHECK_PWR);
    wait_idle;
    rc(1'b0, ADDR_SCNT, 8'hFF, PM_IDLE, "power idle");
    chk("power irq", 1, 32'(intrq));
    wr(1'b0, ADDR_STATUS, OP_SLEEP);
    media_err = 1'b1;
    pulse(media_done);
    media_err = 1'b0;
    wait_idle;
    rc(1'b0, ADDR_ERROR, 8'hFF, ERR_ABORT, "media error");
    wait_idle;
    wr(1'b0, ADDR_STATUS, OP_CHECK_PWR);
    wait_idle;
    rc(1'b0, ADDR_SCNT, 8'hFF, PM_SLEEPING, "power sleep");
    wr(1'b1, ADDR_DEVCTL, 8'h02);
    rc(1'b0, ADDR_STATUS, 8'hFF, 8'h50, "clear");
    wr(1'b0, ADDR_STATUS, OP_CHECK_PWR);
    wait_idle;
    chk("masked irq", 0, 32'(intrq));
    rc(1'b0, ADDR_STATUS, 8'hFF, 8'h50, "clear");
    wr(1'b1, ADDR_DEVCTL, 8'hF9);
    wr(1'b0, ADDR_STATUS, OP_CHECK_PWR);
    wait_idle;
    chk("unmasked irq", 1, 32'(intrq));
    done_test("power and mask");
    foreach (codes[i]) begin
      diag_code = codes[i];
      wr(1'b0, ADDR_DEVHEAD, 8'h10);
      atfcc_host_model_i.xfer(1'b0, 1'b1, 1'b1, ADDR_ERROR, 1'b1, 16'h0000, r, o);
      chk("other card enable", 0, 32'(o));
      wr(1'b0, ADDR_STATUS, OP_DIAG);
      repeat (4) @(negedge clk);
      wr(1'b0, ADDR_DEVHEAD, 8'h00);
      rc(1'b0, ADDR_ERROR, 8'hFF, codes[i], "diag code");
    end
    wr(1'b0, ADDR_STATUS, 8'h00);
    wait_idle;
    rc(1'b0, ADDR_ERROR, 8'hFF, ERR_ABORT, "unknown opcode");
    rc(1'b0, ADDR_STATUS, 8'hFF, 8'h51, "error status");
    done_test("diag");
    wr(1'b0, ADDR_STATUS, OP_FLUSH);
    rc(1'b1, ADDR_DEVCTL, 8'h80, 8'h80, "flush busy");
    chk("flush request", 1, n_flush);
    pulse(flush_done);
    wait_idle;
    rc(1'b0, ADDR_STATUS, 8'hFF, 8'h50, "flush ok");
    fail_lba = 28'hA987654;
    wr(1'b0, ADDR_STATUS, OP_FLUSH);
    pulse(flush_fail);
    wait_idle;
    rc(1'b0, ADDR_ERROR, 8'h04, 8'h04, "flush abort");
    rc(1'b0, ADDR_STATUS, 8'h01, 8'h01, "flush error");
    rc(1'b0, ADDR_SNUM, 8'hFF, 8'h54, "bad lba 0");
    rc(1'b0, ADDR_CYL_LO, 8'hFF, 8'h76, "bad lba 1");
    rc(1'b0, ADDR_CYL_HI, 8'hFF, 8'h98, "bad lba 2");
    rc(1'b0, ADDR_DEVHEAD, 8'h0F, 8'h0A, "bad lba 3");
    done_test("flush");
    wr(1'b0, ADDR_DEVHEAD, 8'h40);
    wr(1'b0, ADDR_STATUS, OP_WR_SECT);
    media_drq = 1'b1;
    repeat (3) @(negedge clk);
    rc(1'b1, ADDR_DEVCTL, 8'h88, 8'h08, "write drq");
    chk("drq irq", 1, 32'(intrq));
    rc(1'b1, ADDR_DRVADDR, 8'h40, 8'h00, "write in progress");
    pulse(media_corrected_flag);
    rc(1'b1, ADDR_DEVCTL, 8'h0C, 8'h0C, "corrected");
    media_drq = 1'b0;
    for (int i = 0; i < 256; i++) begin
      atfcc_host_model_i.xfer(1'b0, 1'b1, 1'b1, ADDR_DATA, 1'b0, 16'(i), r, o);
    end
    chk("written words", 256, n_wr);
    chk("last word", 32'hFF, 32'(media_wdata));
    media_fault = 1'b1;
    pulse(media_done);
    media_fault = 1'b0;
    wait_idle;
    rc(1'b0, ADDR_STATUS, 8'h20, 8'h20, "write fault");
    done_test("write");
    wr(1'b0, ADDR_STATUS, OP_IDENTIFY);
    repeat (3) @(negedge clk);
    rc(1'b1, ADDR_DEVCTL, 8'h88, 8'h08, "identify drq");
    for (int i = 0; i < 256; i++) begin
      atfcc_host_model_i.xfer(1'b0, 1'b1, 1'b1, ADDR_DATA, 1'b1, 16'h0000, r, o);
      if (i == 0) chk("word 0", 32'(ID_W0), 32'(r));
      if (i == 47) chk("word 47", 32'(ID_W47), 32'(r));
      if (i == 48) chk("reserved word", 0, 32'(r));
    end
    wait_idle;
    rc(1'b0, ADDR_STATUS, 8'hFF, 8'h50, "identify end");
    done_test("identify");
    wr(1'b0, ADDR_STATUS, OP_RD_SECT);
    wr(1'b1, ADDR_DEVCTL, 8'h04);
    rc(1'b1, ADDR_DEVCTL, 8'hC0, 8'h80, "in soft reset");
    repeat (10) @(negedge clk);
    rc(1'b1, ADDR_DEVCTL, 8'hC0, 8'h80, "still in reset");
    wr(1'b1, ADDR_DEVCTL, 8'h00);
    wait_idle;
    rc(1'b0, ADDR_SCNT, 8'hFF, 8'h01, "count after reset");
    rc(1'b0, ADDR_DEVHEAD, 8'hFF, 8'hA0, "selector after reset");
    done_test("soft reset");
    close_out;
  end
endmodule
